// >>> testbench.sv
// Self-checking bench of the wake-up frame detector.
// Assumes the detector, its checker and the frame source are compiled.
`timescale 1ns/1ps
module testbench;
  import wfd_pkg::*;
  logic clk_in, reset_in, wr_s, rd_s, d1, start, gap, good, dam;
  logic rx_v, rx_sof, rx_end, rx_good, rx_da, busy, pass, wake, irq, power_event_output;
  wfd_byte_t addr, rx_d, off;
  wfd_word_t wdata, rdata, mask, crc, w0;
  logic [511:0] frame;
  logic [47:0] da;
  logic [31:0] seed;
  int num_errors, cmp_count, idx;
  int wake_cnt = 0;
  int cyc = 0;
  wfd_detector u_wfd_detector (.clk_in(clk_in), .reset_in(reset_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_s),
    .reg_read_in(rd_s), .reg_rdata_out(rdata), .power_state_d1_in(d1),
    .rx_valid_in(rx_v), .rx_sof_in(rx_sof), .rx_data_in(rx_d),
    .rx_end_in(rx_end), .rx_good_in(rx_good), .rx_da_match_in(rx_da),
    .rx_pass_enable_out(pass), .wake_detect_out(wake), .irq_out(irq),
    .power_event_output_out(power_event_output));
  wfd_rx_source u_wfd_rx_source (.clk_in(clk_in), .reset_in(reset_in),
    .start_in(start), .gap_in(gap), .good_in(good), .da_in(dam),
    .frame_in(frame), .rx_valid_out(rx_v), .rx_sof_out(rx_sof),
    .rx_data_out(rx_d), .rx_end_out(rx_end), .rx_good_out(rx_good),
    .rx_da_out(rx_da), .busy_out(busy));
  // ==========================================================
  // Clock, monitor and time limit
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
    if (cyc == 20000) begin
      num_errors++;
      $display("CHECK FAILED at %0t: time limit", $time);
      tally_and_finish();
    end
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Reference CRC: init all ones, bytes LSB first, shift left.
  function automatic wfd_crc_t crc_of(input logic [511:0] f,
    input wfd_word_t m, input int o);
    wfd_crc_t c;
    logic fb;
    c = 16'hffff;
    for (int j = 0; j < 31; j++) if (m[j]) begin
      for (int k = 0; k < 8; k++) begin
        fb = c[15] ^ f[(o+j)*8+k];
        c = {c[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0000);
      end
    end
    return c;
  endfunction
  task automatic chk(input wfd_word_t got, input wfd_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input wfd_byte_t a, input wfd_word_t d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input wfd_byte_t a, input wfd_word_t m, input wfd_word_t e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    @(negedge clk_in);
    chk(rdata & m, e);
    @(posedge clk_in);
  endtask
  task automatic send(input logic ok, input logic hit, input logic slow);
    frame[47:0] <= da;
    good <= ok;
    dam <= hit;
    gap <= slow;
    start <= 1'b1;
    @(posedge clk_in);
    start <= 1'b0;
    repeat (2) @(posedge clk_in);
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk_in);
    repeat (4) @(posedge clk_in);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {reset_in, wr_s, rd_s, d1, start, gap, good, dam} = 8'h80;
    {addr, wdata, da} = 88'h0;
    {seed, num_errors, cmp_count} = {32'd70, 64'd0};
    for (int i = 0; i < 16; i++) frame[i*32 +: 32] = rnd();
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    chk(32'(pass), 1);
    rd(8'h04, '1, 0);
    rd(8'h08, '1, 0);
    wr(8'h20, '1);
    rd(8'h20, '1, 0);
    rd(8'h00, '1, 0);
    $display("test reset finished");
    mask = (rnd() & 32'h7fff_fffc) | 32'h2;
    off = 8'd12 + 8'(rnd() % 8);
    crc = 32'(crc_of(frame, mask, int'(off)));
    repeat (4) wr(8'h00, mask);
    rd(8'h04, 32'h700, 32'h400);
    wr(8'h00, 32'h0800_0901);
    wr(8'h00, {4{off}});
    repeat (2) wr(8'h00, {2{crc[15:0]}});
    rd(8'h04, 32'h700, 0);
    wr(8'h10, 32'h1);
    wr(8'h04, 32'h9);
    chk(32'(pass), 0);
    for (int i = 0; i < 7; i++) begin
      w0 = wake_cnt;
      da = (i == 6) ? '1 : 48'({rnd(), rnd()}) & ~48'h1 | 48'(i == 1);
      idx = int'(off) + i - 2;
      if (i == 2 || i == 3) frame[idx*8 +: 8] <= ~frame[idx*8 +: 8];
      send(i != 4, i != 5 && i != 6, i[0]);
      if (i == 2 || i == 3) frame[idx*8 +: 8] <= ~frame[idx*8 +: 8];
      chk(wake_cnt - w0, 32'(i < 3 || i == 6));
    end
    $display("test filters finished");
    rd(8'h08, 32'h1, 32'h1);
    chk(32'(irq), 1);
    rd(8'h04, 32'h4, 32'h4);
    rd(8'h04, 32'h19, 32'h19);
    rd(8'h08, 32'h2, 32'h2);
    wr(8'h0c, 32'h3);
    chk(32'(irq), 0);
    wr(8'h10, 32'h0);
    send(1'b1, 1'b1, 1'b0);
    rd(8'h08, 32'h1, 32'h1);
    chk(32'(irq), 0);
    wr(8'h0c, 32'h3);
    wr(8'h04, 32'h5);
    wr(8'h04, 32'h3);
    chk(32'(power_event_output), 0);
    send(1'b1, 1'b1, 1'b1);
    chk(32'(power_event_output), 1);
    rd(8'h08, 32'h1, 32'h0);
    wr(8'h04, 32'h7);
    chk(32'(power_event_output), 0);
    $display("test report finished");
    wr(8'h04, 32'h0);
    chk(32'(pass), 1);
    w0 = wake_cnt;
    send(1'b1, 1'b1, 1'b0);
    chk(wake_cnt - w0, 0);
    d1 <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk(32'(pass), 0);
    send(1'b1, 1'b1, 1'b0);
    chk(wake_cnt - w0, 1);
    d1 <= 1'b0;
    $display("test power finished");
    tally_and_finish();
  end
endmodule // testbench

// >>> wfd_crc16.sv
// One CRC-16 engine of a pattern filter, fed one byte per clock.
// Assumes the caller asserts shift only for bytes the filter selects.
`timescale 1ns/1ps
`include "wfd_defs.svh"
module wfd_crc16 (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clear_in,
  input wire logic shift_in,
  input wire wfd_pkg::wfd_byte_t data_in,
  output wfd_pkg::wfd_crc_t crc_out
);
  import wfd_pkg::*;
  typedef struct packed {
    wfd_crc_t crc;
  } wfd_crc_state_t;
  wfd_crc_state_t st_r;
  wfd_crc_state_t st_nxt;
  wfd_crc_t seed;
  wfd_crc_t acc;
  logic fb;
  // ==========================================================
  // Bytewise update, least significant bit first as on the wire
  always_comb begin
    st_nxt = st_r;
    seed = clear_in ? `WFD_CRC_INIT : st_r.crc;
    acc = seed;
    fb = 1'b0;
    for (int b = 0; b < 8; b++) begin
      fb = acc[15] ^ data_in[b];
      acc = {acc[14:0], 1'b0} ^ (fb ? `WFD_CRC_POLY : 16'h0000); // RL19
    end
    if (shift_in) begin
      st_nxt.crc = acc; // RL8
    end else if (clear_in) begin
      st_nxt.crc = `WFD_CRC_INIT;
    end
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_r <= '{crc: `WFD_CRC_INIT};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign crc_out = st_r.crc;
endmodule // wfd_crc16

// >>> wfd_defs.svh
// Constants of the wake-up frame detector: offsets, fields, resets, counts.
// Assumes inclusion by the package and the design files by bare name.
`ifndef WFD_DEFS_SVH
`define WFD_DEFS_SVH
// ==========================================================
// Register offsets
`define WFD_OFS_FILTER 8'h00
`define WFD_OFS_CTRL 8'h04
`define WFD_OFS_IST 8'h08
`define WFD_OFS_ICLR 8'h0c
`define WFD_OFS_IEN 8'h10
// ==========================================================
// Control and status fields
`define WFD_CTL_ENABLE 0
`define WFD_CTL_PME_SEL 1
`define WFD_CTL_RECEIVED 2
`define WFD_CTL_BROADCAST_DISABLE_DIS 3
`define WFD_CTL_ACTIVE 4
`define WFD_CTL_PTR_LO 8
// ==========================================================
// Interrupt event bits
`define WFD_EV_WAKE 0
`define WFD_EV_CHECKED 1
`define WFD_EV_W 2
// ==========================================================
// Filter word fields
`define WFD_CMD_ENABLE 0
`define WFD_CMD_MCAST 3
`define WFD_MASK_BITS 31
`define WFD_MASK_LAST 11'd30
`define WFD_FILTERS 4
`define WFD_LOAD_LAST 3'd7
// ==========================================================
// Reset values and CRC settings
`define WFD_RST_WORD 32'h0000_0000
`define WFD_CRC_POLY 16'h8005
`define WFD_CRC_INIT 16'hffff
`define WFD_DA_LAST 11'd5
`endif

// >>> wfd_detector.sv
// Wake-up frame detector of the MAC receive path, with its registers.
// Assumes receive bytes, station match and frame status come from logic
// on clk_in, so none of them is synchronised here.
`timescale 1ns/1ps
`include "wfd_defs.svh"
// Overview of operation
// RL1: Enable bit puts block in detection mode, halts normal reception.
// RL2: Detection reported on host interrupt or on power event output.
// RL3: A detected wake frame sets the received bit in control status.
// RL4: Clearing the enable bit leaves detection and resumes reception.
// RL5: Host programs patterns and masks before enabling detection.
// RL6: Four filters; a match needs address type and CRC agreement.
// RL7: In wake mode every station frame is tested on enabled filters.
// RL8: Byte offset plus j enters the CRC only when mask bit j is set.
// RL9: Software writes zero to bit 31 of every byte mask word.
// RL10: Eight writes load masks, command, offset, then CRC pairs.
// RL11: Command bit 3 set means multicast only, clear unicast only.
// RL12: Command bit 0 enables the filter; bits 2:1 are reserved.
// RL13: Offset field gives first byte checked; zero is first DA byte.
// RL14: Software keeps every pattern offset at twelve or more.
// RL15: D0 follows the enable bit; D1 forces detection on.
// RL16: Broadcast wake frames wake despite the broadcast disable bit.
// RL17: Each filter holds a sixteen bit expected CRC value.
// RL18: Computed CRC equal to the stored value means a wake frame.
// RL19: CRC-16 uses polynomial 0x8005 over selected bytes in order.
module wfd_detector (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire wfd_pkg::wfd_byte_t reg_addr_in,
  input wire wfd_pkg::wfd_word_t reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output wfd_pkg::wfd_word_t reg_rdata_out,
  input wire logic power_state_d1_in,
  input wire logic rx_valid_in,
  input wire logic rx_sof_in,
  input wire wfd_pkg::wfd_byte_t rx_data_in,
  input wire logic rx_end_in,
  input wire logic rx_good_in,
  input wire logic rx_da_match_in,
  output logic rx_pass_enable_out,
  output logic wake_detect_out,
  output logic irq_out,
  output logic power_event_output_out
);
  import wfd_pkg::*;

  // ==========================================================
  // State of the block
  typedef struct packed {
    wfd_word_t [`WFD_FILTERS-1:0] mask;
    wfd_word_t cmd;
    wfd_word_t offs;
    wfd_word_t crc01;
    wfd_word_t crc23;
    logic [2:0] load_ptr;
    logic wake_frame_enable;
    logic pme_sel;
    logic wake_frame_received;
    logic broadcast_disable;
    logic active;
    logic [`WFD_EV_W-1:0] ist;
    logic [`WFD_EV_W-1:0] ien;
    wfd_rx_state_t rx_state;
    wfd_pos_t pos;
    logic da_mcast;
    logic da_broadcast_disable;
    logic wake_pulse;
    wfd_word_t rdata;
  } wfd_state_t;

  wfd_state_t st_r;
  wfd_state_t st_nxt;

  wfd_crc_t crc_calc [`WFD_FILTERS];
  wfd_crc_t crc_want [`WFD_FILTERS];
  logic [`WFD_FILTERS-1:0] sel;
  logic [`WFD_FILTERS-1:0] hit;
  logic byte_take;
  logic frame_first;
  wfd_pos_t cur_pos;
  logic cur_mcast;
  logic cur_broadcast_disable;
  logic addr_ok;
  logic any_hit;
  logic frame_done;
  logic wr_ctrl;
  logic [`WFD_EV_W-1:0] ev;

  // ==========================================================
  // Byte position of the incoming frame
  assign frame_first = rx_valid_in && rx_sof_in;
  assign byte_take = rx_valid_in &&
    (rx_sof_in || st_r.rx_state == WFD_FRAME);
  assign cur_pos = frame_first ? 11'd0 : st_r.pos;

  // Multicast and broadcast are judged from the destination address.
  always_comb begin
    cur_mcast = st_r.da_mcast;
    cur_broadcast_disable = st_r.da_broadcast_disable;
    if (byte_take && cur_pos == 11'd0) begin
      cur_mcast = rx_data_in[0];
    end
    if (byte_take && cur_pos <= `WFD_DA_LAST) begin
      cur_broadcast_disable = (frame_first || st_r.da_broadcast_disable) &&
        rx_data_in == 8'hff;
    end
  end

  // ==========================================================
  // Per filter byte selection, CRC engine and match
  generate
    for (genvar i = 0; i < `WFD_FILTERS; i++) begin : g_filt
      wfd_byte_t off_i;
      wfd_pos_t rel;
      logic in_win;
      assign off_i = st_r.offs[8*i +: 8]; // RL13
      assign rel = cur_pos - {3'b000, off_i};
      assign in_win = cur_pos >= {3'b000, off_i} &&
        rel <= `WFD_MASK_LAST;
      // Bit 31 of the mask never selects a byte, whatever is written.
      assign sel[i] = byte_take && st_r.active && in_win &&
        st_r.mask[i][rel[4:0]]; // RL8
      if (i < 2) begin : g_lo
        assign crc_want[i] = st_r.crc01[16*i +: 16]; // RL17
      end else begin : g_hi
        assign crc_want[i] = st_r.crc23[16*(i-2) +: 16]; // RL17
      end
      wfd_crc16 u_crc (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .clear_in(frame_first),
        .shift_in(sel[i]),
        .data_in(rx_data_in),
        .crc_out(crc_calc[i])
      );
      assign hit[i] = st_r.cmd[8*i + `WFD_CMD_ENABLE] && // RL12
        (st_r.cmd[8*i + `WFD_CMD_MCAST] == st_r.da_mcast) && // RL11
        crc_calc[i] == crc_want[i]; // RL18
    end
  endgenerate

  // Broadcast frames count as addressed here even when the MAC would
  // drop them, so a broadcast wake pattern still wakes the station.
  assign addr_ok = rx_da_match_in || st_r.da_broadcast_disable; // RL16
  assign any_hit = |hit; // RL6
  assign frame_done = rx_end_in && st_r.rx_state == WFD_FRAME &&
    st_r.active;
  assign wr_ctrl = reg_write_in && reg_addr_in == `WFD_OFS_CTRL;

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    ev = '0;
    st_nxt.wake_pulse = 1'b0;
    st_nxt.rdata = '0;

    // Receive framing.
    case (st_r.rx_state)
      WFD_IDLE: begin
        if (frame_first) begin
          st_nxt.rx_state = WFD_FRAME;
          st_nxt.pos = 11'd1;
        end
      end
      WFD_FRAME: begin
        if (rx_end_in) begin
          st_nxt.rx_state = WFD_IDLE;
        end else if (frame_first) begin
          st_nxt.pos = 11'd1;
        end else if (rx_valid_in && st_r.pos != 11'h7ff) begin
          st_nxt.pos = st_r.pos + 11'd1;
        end
      end
      default: begin
        st_nxt.rx_state = WFD_IDLE;
      end
    endcase
    if (byte_take) begin
      st_nxt.da_mcast = cur_mcast;
      st_nxt.da_broadcast_disable = cur_broadcast_disable;
    end

    // Frame verdict at the frame end.
    if (frame_done && rx_good_in && addr_ok) begin // RL7
      ev[`WFD_EV_CHECKED] = 1'b1;
      if (any_hit) begin
        st_nxt.wake_pulse = 1'b1;
        ev[`WFD_EV_WAKE] = !st_r.pme_sel; // RL2
      end
    end

    // Register writes.
    if (reg_write_in) begin
      case (reg_addr_in)
        `WFD_OFS_FILTER: begin
          case (st_r.load_ptr) // RL10
            3'd0: st_nxt.mask[0] = reg_wdata_in;
            3'd1: st_nxt.mask[1] = reg_wdata_in;
            3'd2: st_nxt.mask[2] = reg_wdata_in;
            3'd3: st_nxt.mask[3] = reg_wdata_in;
            3'd4: st_nxt.cmd = reg_wdata_in;
            3'd5: st_nxt.offs = reg_wdata_in;
            3'd6: st_nxt.crc01 = reg_wdata_in;
            default: st_nxt.crc23 = reg_wdata_in;
          endcase
          st_nxt.load_ptr = st_r.load_ptr == `WFD_LOAD_LAST ?
            3'd0 : st_r.load_ptr + 3'd1; // RL10
        end
        `WFD_OFS_CTRL: begin
          st_nxt.wake_frame_enable =
            reg_wdata_in[`WFD_CTL_ENABLE]; // RL1 RL4
          st_nxt.pme_sel = reg_wdata_in[`WFD_CTL_PME_SEL];
          st_nxt.broadcast_disable =
            reg_wdata_in[`WFD_CTL_BROADCAST_DISABLE_DIS];
        end
        `WFD_OFS_ICLR: begin
          st_nxt.ist = st_r.ist &
            ~reg_wdata_in[`WFD_EV_W-1:0];
        end
        `WFD_OFS_IEN: begin
          st_nxt.ien = reg_wdata_in[`WFD_EV_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Sticky flags: a new event wins over a clear in the same cycle.
    if (wr_ctrl && reg_wdata_in[`WFD_CTL_RECEIVED]) begin
      st_nxt.wake_frame_received = 1'b0;
    end
    if (st_r.wake_pulse) begin
      st_nxt.wake_frame_received = 1'b1; // RL3
    end
    st_nxt.ist = st_nxt.ist | ev;

    // Detection mode: enable bit in D0, forced in D1.
    st_nxt.active = st_nxt.wake_frame_enable ||
      power_state_d1_in; // RL15 RL1 RL4

    // Register reads; data stands in the following cycle only.
    if (reg_read_in) begin
      case (reg_addr_in)
        `WFD_OFS_CTRL: begin
          st_nxt.rdata[`WFD_CTL_ENABLE] = st_r.wake_frame_enable;
          st_nxt.rdata[`WFD_CTL_PME_SEL] = st_r.pme_sel;
          st_nxt.rdata[`WFD_CTL_RECEIVED] = st_r.wake_frame_received;
          st_nxt.rdata[`WFD_CTL_BROADCAST_DISABLE_DIS] = st_r.broadcast_disable;
          st_nxt.rdata[`WFD_CTL_ACTIVE] = st_r.active;
          st_nxt.rdata[`WFD_CTL_PTR_LO +: 3] = st_r.load_ptr;
        end
        `WFD_OFS_IST: begin
          st_nxt.rdata[`WFD_EV_W-1:0] = st_r.ist;
        end
        `WFD_OFS_IEN: begin
          st_nxt.rdata[`WFD_EV_W-1:0] = st_r.ien;
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_r <= '{
        mask: '0,
        cmd: `WFD_RST_WORD,
        offs: `WFD_RST_WORD,
        crc01: `WFD_RST_WORD,
        crc23: `WFD_RST_WORD,
        load_ptr: 3'd0,
        wake_frame_enable: 1'b0,
        pme_sel: 1'b0,
        wake_frame_received: 1'b0,
        broadcast_disable: 1'b0,
        active: 1'b0,
        ist: '0,
        ien: '0,
        rx_state: WFD_IDLE,
        pos: 11'd0,
        da_mcast: 1'b0,
        da_broadcast_disable: 1'b0,
        wake_pulse: 1'b0,
        rdata: `WFD_RST_WORD
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata_out = st_r.rdata;
  assign rx_pass_enable_out = !st_r.active; // RL1 RL4
  assign wake_detect_out = st_r.wake_pulse;
  assign irq_out = |(st_r.ist & st_r.ien); // RL2
  assign power_event_output_out = st_r.pme_sel &&
    st_r.wake_frame_received; // RL2
endmodule // wfd_detector

// >>> wfd_pkg.sv
// Types shared by the wake-up frame detector files.
// Assumes wfd_defs.svh is on the include path.
`include "wfd_defs.svh"
package wfd_pkg;
  // ==========================================================
  // Receive framing states
  typedef enum logic [1:0] {
    WFD_IDLE = 2'b01,
    WFD_FRAME = 2'b10
  } wfd_rx_state_t;
  typedef logic [7:0] wfd_byte_t;
  typedef logic [15:0] wfd_crc_t;
  typedef logic [31:0] wfd_word_t;
  typedef logic [10:0] wfd_pos_t;
endpackage

// >>> wfd_props_properties.sv
// Port assertions for the wake-up frame detector.
// Assumes it is bound to every wfd_detector instance below.
`timescale 1ns/1ps
module wfd_props (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire wfd_pkg::wfd_byte_t reg_addr_in,
  input wire wfd_pkg::wfd_word_t reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire wfd_pkg::wfd_word_t reg_rdata_out,
  input wire logic power_state_d1_in,
  input wire logic rx_end_in,
  input wire logic rx_good_in,
  input wire logic rx_pass_enable_out,
  input wire logic wake_detect_out,
  input wire logic irq_out,
  input wire logic power_event_output_out
);
  import wfd_pkg::*;
  logic ctl_wr;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  assign ctl_wr = reg_write_in && reg_addr_in == 8'h04;
  // ==========================================================
  // Properties
  a_enable_stops_rx: assert property (
    ctl_wr && reg_wdata_in[0] |=> !rx_pass_enable_out)
    else $error("Reception stayed on after enable.");
  a_disable_resumes: assert property (
    ctl_wr && !reg_wdata_in[0] && !power_state_d1_in |=> rx_pass_enable_out)
    else $error("Reception stayed off after disable.");
  a_d1_forces_on: assert property (
    power_state_d1_in |=> !rx_pass_enable_out)
    else $error("D1 did not force detection.");
  a_wake_has_cause: assert property (
    wake_detect_out |-> $past(rx_end_in) && $past(rx_good_in)
      && !$past(rx_pass_enable_out))
    else $error("Wake without a good frame end in wake mode.");
  a_wake_one_pulse: assert property (
    wake_detect_out |=> !wake_detect_out)
    else $error("Wake pulse too long.");
  a_pme_has_cause: assert property (
    $rose(power_event_output_out) |-> $past(wake_detect_out) || $past(ctl_wr))
    else $error("Power event without a wake.");
  a_irq_fall_write: assert property (
    $fell(irq_out) |-> $past(reg_write_in))
    else $error("Interrupt dropped without a write.");
  a_irq_rise_cause: assert property (
    $rose(irq_out) |-> $past(rx_end_in) || $past(reg_write_in))
    else $error("Interrupt rose without a cause.");
  a_rdata_zero: assert property (
    !reg_read_in || reg_addr_in == 8'h00 |=> reg_rdata_out == 32'h0)
    else $error("Read data not zero.");
endmodule // wfd_props

bind wfd_detector wfd_props u_wfd_props (.clk_in(clk_in),
  .reset_in(reset_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .power_state_d1_in(power_state_d1_in), .rx_end_in(rx_end_in),
  .rx_good_in(rx_good_in), .rx_pass_enable_out(rx_pass_enable_out),
  .wake_detect_out(wake_detect_out), .irq_out(irq_out),
  .power_event_output_out(power_event_output_out));

// >>> wfd_rx_source.sv
// Receive side model: sends one 64-byte frame, then the end pulse.
// Assumes the bench holds the frame steady while busy_out is high.
`timescale 1ns/1ps
module wfd_rx_source (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic start_in,
  input wire logic gap_in,
  input wire logic good_in,
  input wire logic da_in,
  input wire logic [511:0] frame_in,
  output logic rx_valid_out,
  output logic rx_sof_out,
  output logic [7:0] rx_data_out,
  output logic rx_end_out,
  output logic rx_good_out,
  output logic rx_da_out,
  output logic busy_out
);
  int pos;
  logic hold;
  // ==========================================================
  // Frame sender
  // Idle data toggles each cycle between the inverse of the last byte and the byte itself.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pos <= 0;
      hold <= 1'b0;
      busy_out <= 1'b0;
      {rx_valid_out, rx_sof_out, rx_end_out} <= 3'b000;
      {rx_data_out, rx_good_out, rx_da_out} <= 10'h0;
    end else begin
      {rx_valid_out, rx_sof_out, rx_end_out} <= 3'b000;
      rx_data_out <= ~rx_data_out;
      rx_good_out <= ~good_in;
      rx_da_out <= ~da_in;
      if (!busy_out) begin
        busy_out <= start_in;
        pos <= 0;
        hold <= 1'b0;
      end else if (pos == 64) begin
        rx_end_out <= 1'b1;
        rx_good_out <= good_in;
        rx_da_out <= da_in;
        busy_out <= 1'b0;
      end else if (hold) begin
        hold <= 1'b0;
      end else begin
        rx_valid_out <= 1'b1;
        rx_sof_out <= pos == 0;
        rx_data_out <= frame_in[pos*8 +: 8];
        pos <= pos + 1;
        hold <= gap_in;
      end
    end
  end
endmodule // wfd_rx_source
